// ==== hdl/cell_protection_defines.svh ====
/*
 * Timing constants for the cell protection state controller.
 * Assumes a 10 MHz system clock; counts are derived from the printed times.
 */
`ifndef CELL_PROTECTION_DEFINES_SVH
`define CELL_PROTECTION_DEFINES_SVH

`define CLK_HZ                 10000000
`define OVERCHARGE_DELAY_MS    100
`define OVERDISCHARGE_DELAY_MS 60
`define OVERCURRENT_DELAY_MS   4
`define LOAD_SHORT_DELAY_US    50
`define OVERCHARGE_DELAY_CYC    (`OVERCHARGE_DELAY_MS * (`CLK_HZ / 1000))
`define OVERDISCHARGE_DELAY_CYC (`OVERDISCHARGE_DELAY_MS * (`CLK_HZ / 1000))
`define OVERCURRENT_DELAY_CYC   (`OVERCURRENT_DELAY_MS * (`CLK_HZ / 1000))
`define LOAD_SHORT_DELAY_CYC    (`LOAD_SHORT_DELAY_US * (`CLK_HZ / 1000000))

`endif

// ==== hdl/cell_protection_pkg.sv ====
/*
 * Types shared by the cell protection controller, its checker, cell model and bench.
 * Assumes the comparator flags arrive from the analog front end.
 */
package cell_protection_pkg;

    typedef enum logic [2:0]
    {
        st_normal        = 3'b000,
        st_overcharge    = 3'b001,
        st_overcurrent   = 3'b100,
        st_overdischarge = 3'b010,
        st_powerdown     = 3'b110
    } prot_state_t;

    typedef struct packed
    {
        logic cell_above_overcharge;
        logic cell_below_overcharge_release;
        logic cell_below_overdischarge_trip;
        logic cell_above_overdischarge_release;
        logic sense_load_connect;
        logic sense_overcurrent;
        logic sense_load_short;
        logic sense_above_powerdown;
        logic sense_charger_present;
        logic sense_below_charger_level;
        logic load_removed;
        logic overtemp;
    } sense_flags_t;

    typedef struct packed
    {
        logic charge_enable;
        logic discharge_enable;
        logic powerdown;
        logic sense_to_ground_pulldown;
    } switch_ctrl_t;

endpackage

// ==== hdl/fault_delay_timer.sv ====
/*
 * Qualifies one fault flag: reports it only after it has held for DELAY cycles.
 * Assumes the flag is already synchronised to clk.
 */
`timescale 1ns/1ps
module fault_delay_timer
#(
    parameter int DELAY = 4
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic flag,
    output logic      expired
);
    localparam int W = $clog2(DELAY + 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_expired;

    // A flag that drops, even for one cycle, starts the wait again.
    always_comb
    begin
        next_count   = count;
        next_expired = 1'b0;
        if (!enable || !flag)
        begin
            next_count = '0; // RL20
        end
        else if (count >= W'(DELAY - 1))
        begin
            next_expired = 1'b1;
        end
        else
        begin
            next_count = count + W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count   <= '0;
            expired <= 1'b0;
        end
        else
        begin
            count   <= next_count;
            expired <= next_expired;
        end
    end
endmodule

// ==== hdl/cell_protection_state_controller.sv ====
/*
 * Protection state controller for a single lithium cell: times comparator
 * flags and drives the charge, discharge, power-down and pull-down enables.
 * Assumes comparator flags come from the analog domain and a 10 MHz clock.
 */
// Overview of operation
// RL1 - With no fault active, both charge and discharge switches stay enabled.
// RL2 - Overcharge flag held for overcharge delay disables charge, enters overcharge.
// RL3 - In overcharge, cell below release level re-enables charge, returns normal.
// RL4 - In overcharge, load connect with cell not above trip returns to normal.
// RL5 - Load appearing with cell above overcharge trip keeps overcharge state.
// RL6 - Sense node on overcurrent side during load connect keeps overcharge state.
// RL7 - Load short is acted on in every state and any cell voltage; the code times it in every state but overcurrent.
// RL8 - Over-discharge flag held for its delay disables discharge, enters over-discharge.
// RL9 - In over-discharge, sense node above 1.5V enters power-down, asserts power-down.
// RL10 - Charger giving 1.3V sense difference leaves power-down, discharge still off.
// RL11 - After power-down release, cell at trip level or above returns normal.
// RL12 - Charger present, sense not below charger level, cell released: discharge on.
// RL13 - Overcurrent flag held for its delay disables discharge, enters overcurrent.
// RL14 - In overcurrent, the sense-to-ground pull-down enable is asserted.
// RL15 - Overcurrent ends only when load removed and impedance above recovery level.
// RL16 - Overcharge delay is nominally 100 ms.
// RL17 - Over-discharge delay is nominally 60 ms.
// RL18 - Overcurrent delay is nominally 4 ms.
// RL19 - Load short delay is nominally 50 us.
// RL20 - Each delay timer restarts when its flag clears before expiry.
// RL21 - Over-temperature disables both switches until the flag clears.
`timescale 1ns/1ps
`include "cell_protection_defines.svh"
module cell_protection_state_controller
#(
    parameter int OVERCHARGE_DELAY    = `OVERCHARGE_DELAY_CYC,
    parameter int OVERDISCHARGE_DELAY = `OVERDISCHARGE_DELAY_CYC,
    parameter int OVERCURRENT_DELAY   = `OVERCURRENT_DELAY_CYC,
    parameter int LOAD_SHORT_DELAY    = `LOAD_SHORT_DELAY_CYC
)
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire cell_protection_pkg::sense_flags_t flags_async,
    output cell_protection_pkg::switch_ctrl_t      ctrl,
    output cell_protection_pkg::prot_state_t       state
);
    import cell_protection_pkg::*;

    sense_flags_t flags_meta;
    sense_flags_t flags;
    prot_state_t  next_state;
    switch_ctrl_t next_ctrl;
    logic         overcharge_hit;
    logic         overdischarge_hit;
    logic         overcurrent_hit;
    logic         load_short_hit;

    // The slow fault timers are armed only in the normal state; elsewhere they
    // are held at zero so that a stale count cannot fire on the way back.
    function automatic logic timers_armed(input prot_state_t st);
        return (st == st_normal);
    endfunction

    // Comparator outputs are asynchronous to clk, so each passes two flops.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_meta <= '0;
            flags      <= '0;
        end
        else
        begin
            flags_meta <= flags_async;
            flags      <= flags_meta;
        end
    end

    fault_delay_timer #(.DELAY(OVERCHARGE_DELAY)) u_overcharge_timer // RL16
    (
        .clk     (clk),
        .rst     (rst),
        .enable  (timers_armed(state)),
        .flag    (flags.cell_above_overcharge),
        .expired (overcharge_hit)
    );

    fault_delay_timer #(.DELAY(OVERDISCHARGE_DELAY)) u_overdischarge_timer // RL17
    (
        .clk     (clk),
        .rst     (rst),
        .enable  (timers_armed(state)),
        .flag    (flags.cell_below_overdischarge_trip),
        .expired (overdischarge_hit)
    );

    fault_delay_timer #(.DELAY(OVERCURRENT_DELAY)) u_overcurrent_timer // RL18
    (
        .clk     (clk),
        .rst     (rst),
        .enable  (timers_armed(state)),
        .flag    (flags.sense_overcurrent),
        .expired (overcurrent_hit)
    );

    // The short timer runs in every state but overcurrent itself.
    fault_delay_timer #(.DELAY(LOAD_SHORT_DELAY)) u_load_short_timer // RL19
    (
        .clk     (clk),
        .rst     (rst),
        .enable  (state != st_overcurrent),
        .flag    (flags.sense_load_short),
        .expired (load_short_hit)
    );

    always_comb
    begin
        next_state = state;
        if (load_short_hit)
        begin
            next_state = st_overcurrent; // RL7
        end
        else
        begin
            unique case (state)
                st_normal:
                begin
                    if (overcurrent_hit)
                    begin
                        next_state = st_overcurrent; // RL13
                    end
                    else if (overdischarge_hit)
                    begin
                        next_state = st_overdischarge; // RL8
                    end
                    else if (overcharge_hit)
                    begin
                        next_state = st_overcharge; // RL2
                    end
                end
                st_overcharge:
                begin
                    if (flags.cell_below_overcharge_release)
                    begin
                        next_state = st_normal; // RL3
                    end
                    // Load connect releases only below trip and off the overcurrent side.
                    else if (flags.sense_load_connect && !flags.cell_above_overcharge // RL5
                             && !flags.sense_overcurrent) // RL6
                    begin
                        next_state = st_normal; // RL4
                    end
                end
                st_overdischarge:
                begin
                    // A charger that has lifted the cell past release wins over power-down.
                    if (flags.sense_charger_present && !flags.sense_below_charger_level
                        && flags.cell_above_overdischarge_release)
                    begin
                        next_state = st_normal; // RL12
                    end
                    else if (flags.sense_above_powerdown)
                    begin
                        next_state = st_powerdown; // RL9
                    end
                    else if (!flags.cell_below_overdischarge_trip
                             && !flags.sense_above_powerdown)
                    begin
                        next_state = st_normal; // RL11
                    end
                end
                st_powerdown:
                begin
                    if (flags.sense_charger_present)
                    begin
                        next_state = st_overdischarge; // RL10
                    end
                end
                st_overcurrent:
                begin
                    if (flags.load_removed)
                    begin
                        next_state = st_normal; // RL15
                    end
                end
                default:
                begin
                    next_state = st_normal;
                end
            endcase
        end
    end

    // Outputs follow the next state so that they change on the same edge.
    always_comb
    begin
        next_ctrl.charge_enable            = (next_state != st_overcharge); // RL1
        next_ctrl.discharge_enable         = (next_state == st_normal)
                                             || (next_state == st_overcharge); // RL1
        next_ctrl.powerdown                = (next_state == st_powerdown); // RL9
        next_ctrl.sense_to_ground_pulldown = (next_state == st_overcurrent); // RL14
        // Heat gates the switches only; the state is kept so recovery resumes in place.
        if (flags.overtemp)
        begin
            next_ctrl.charge_enable    = 1'b0; // RL21
            next_ctrl.discharge_enable = 1'b0; // RL21
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= st_normal;
            ctrl  <= '{charge_enable: 1'b1, discharge_enable: 1'b1,
                       powerdown: 1'b0, sense_to_ground_pulldown: 1'b0};
        end
        else
        begin
            state <= next_state;
            ctrl  <= next_ctrl;
        end
    end
endmodule

// ==== test/cell_protection_sva.sv ====
/*
 * Concurrent checks on the cell protection controller ports.
 * Assumes it is bound into the controller with the same delay parameters.
 */
`timescale 1ns/1ps
module cell_protection_sva
#(
    parameter int OVERCHARGE_DELAY = 20,
    parameter int LOAD_SHORT_DELAY = 5
)
(
    input wire logic                              clk,
    input wire logic                              rst,
    input wire cell_protection_pkg::sense_flags_t flags_async,
    input wire cell_protection_pkg::switch_ctrl_t ctrl,
    input wire cell_protection_pkg::prot_state_t  state
);
    import cell_protection_pkg::*;
    logic [3:0] ot;
    int         oc_run;
    int         ls_run;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Runs of raw flag samples; the design adds sync latency on top of these.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ot     <= 4'h0;
            oc_run <= 0;
            ls_run <= 0;
        end
        else
        begin
            ot     <= {ot[2:0], flags_async.overtemp};
            oc_run <= flags_async.cell_above_overcharge ? oc_run + 1 : 0;
            ls_run <= flags_async.sense_load_short ? ls_run + 1 : 0;
        end
    end
    chk_idle_both_on:
        assert property (state == st_normal && ot == 4'h0 && !flags_async.overtemp
            |-> ctrl.charge_enable && ctrl.discharge_enable) else $error("switch off idle");
    chk_oc_entry_time:
        assert property ($rose(state == st_overcharge)
            |-> $past(state) == st_normal && oc_run >= OVERCHARGE_DELAY) else $error("early oc");
    chk_oc_charge_off:
        assert property (state == st_overcharge |-> !ctrl.charge_enable) else $error("charge on");
    chk_pulldown_ocur:
        assert property (ctrl.sense_to_ground_pulldown == (state == st_overcurrent))
            else $error("pull-down wrong");
    chk_powerdown_out:
        assert property (ctrl.powerdown == (state == st_powerdown)) else $error("powerdown wrong");
    chk_fault_dis_off:
        assert property (state inside {st_overdischarge, st_powerdown, st_overcurrent}
            |-> !ctrl.discharge_enable) else $error("discharge on in fault");
    chk_short_time:
        assert property (ls_run == LOAD_SHORT_DELAY + 6 |-> state == st_overcurrent)
            else $error("short not taken");
    chk_ot_both_off:
        assert property (ot == 4'hf |-> !ctrl.charge_enable && !ctrl.discharge_enable)
            else $error("switch on when hot");
endmodule
bind cell_protection_state_controller cell_protection_sva
#(
    .OVERCHARGE_DELAY(OVERCHARGE_DELAY),
    .LOAD_SHORT_DELAY(LOAD_SHORT_DELAY)
)
sva
(
    .clk(clk),
    .rst(rst),
    .flags_async(flags_async),
    .ctrl(ctrl),
    .state(state)
);

// ==== test/cell_env_model.sv ====
/*
 * Cell, charger and load as seen through the comparator flags.
 * Assumes the bench sets the external conditions on env.
 */
`timescale 1ns/1ps
module cell_env_model
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire cell_protection_pkg::sense_flags_t env,
    input  wire cell_protection_pkg::switch_ctrl_t ctrl,
    output cell_protection_pkg::sense_flags_t      flags_async
);
    import cell_protection_pkg::*;
    sense_flags_t next_flags;
    // With discharge off and no charger or pull-down, the pull-up lifts the sense node.
    always_comb
    begin
        next_flags = env;
        next_flags.sense_above_powerdown = env.sense_above_powerdown | (!ctrl.discharge_enable
            && !ctrl.sense_to_ground_pulldown && !env.sense_charger_present);
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags_async <= '0;
        else
            flags_async <= next_flags;
    end
endmodule

// ==== test/cell_protection_state_controller_tb.sv ====
/*
 * Directed bench for the cell protection controller.
 * Assumes the package, controller, checker and cell model are compiled first.
 */
`timescale 1ns/1ps
module cell_protection_state_controller_tb;
    import cell_protection_pkg::*;
    localparam int OC  = 20;
    localparam int OD  = 15;
    localparam int OCR = 10;
    localparam int LS  = 5;
    logic         clk;
    logic         rst;
    sense_flags_t env;
    sense_flags_t flags_async;
    switch_ctrl_t ctrl;
    prot_state_t  state;
    logic [6:0]   full;
    logic [6:0]   part;
    int           error_cnt;
    int           checks;
    int           cyc;
    assign full = {ctrl, state};
    assign part = {1'b0, ctrl[2:0], state};
    cell_protection_state_controller #(.OVERCHARGE_DELAY(OC), .OVERDISCHARGE_DELAY(OD),
        .OVERCURRENT_DELAY(OCR), .LOAD_SHORT_DELAY(LS)) dut (.clk(clk), .rst(rst),
        .flags_async(flags_async), .ctrl(ctrl), .state(state));
    cell_env_model model (.clk(clk), .rst(rst), .env(env), .ctrl(ctrl),
        .flags_async(flags_async));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [6:0] seen, input logic [6:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Flag words follow sense_flags_t, msb first (12'h800 is cell_above_overcharge).
    task automatic go(input logic [11:0] f, input int n);
        @(posedge clk);
        env <= sense_flags_t'(f);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_overcharge;
        go(12'h800, OC - 3);
        go(12'h000, 2);
        go(12'h800, OC - 4);
        chk("oc_restart", full, {4'hc, st_normal});
        go(12'h800, 10);
        chk("oc_entry", full, {4'h4, st_overcharge});
        go(12'h880, 8);
        chk("oc_load_high", full, {4'h4, st_overcharge});
        go(12'h0c0, 8);
        chk("oc_load_ocur", full, {4'h4, st_overcharge});
        go(12'h080, 8);
        chk("oc_load_rel", full, {4'hc, st_normal});
        go(12'h800, OC + 6);
        go(12'h400, 6);
        chk("oc_release", full, {4'hc, st_normal});
    endtask
    task automatic t_short;
        go(12'h800, OC + 6);
        go(12'h020, LS + 6);
        chk("short_in_oc", part, {4'h1, st_overcurrent});
        go(12'h000, 6);
        chk("ocur_hold", part, {4'h1, st_overcurrent});
        go(12'h002, 6);
        chk("ocur_rel", full, {4'hc, st_normal});
    endtask
    task automatic t_ocur;
        go(12'h040, OCR - 1);
        chk("ocur_early", full, {4'hc, st_normal});
        go(12'h040, 7);
        chk("ocur_entry", part, {4'h1, st_overcurrent});
        go(12'h002, 6);
        chk("ocur_exit", full, {4'hc, st_normal});
    endtask
    task automatic t_odis;
        go(12'h200, OD);
        chk("od_early", full, {4'hc, st_normal});
        go(12'h200, 14);
        chk("od_pdown", part, {4'h2, st_powerdown});
        go(12'h208, 6);
        chk("pd_release", part, {4'h0, st_overdischarge});
        go(12'h00c, 6);
        chk("od_cell_rel", part, {4'h4, st_normal});
        go(12'h200, OD + 14);
        chk("od_pdown_again", part, {4'h2, st_powerdown});
        go(12'h208, 6);
        go(12'h308, 6);
        chk("od_release", part, {4'h4, st_normal});
    endtask
    task automatic t_otemp;
        go(12'h001, 6);
        chk("ot_off", full, {4'h0, st_normal});
        go(12'h000, 6);
        chk("ot_clear", full, {4'hc, st_normal});
    endtask
    initial
    begin
        rst = 1'b1;
        env = '0;
        error_cnt = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset", full, {4'hc, st_normal});
        t_overcharge;
        t_short;
        t_ocur;
        t_odis;
        t_otemp;
        print_verdict;
    end
    // The scenarios need about 300 cycles; 2000 leaves room without hiding a hang.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            error_cnt++;
            print_verdict;
        end
    end
endmodule
